// >>> core/timer_dio_pkg.sv
// shared constants and types for the timer, digital i/o and interval register bank
package timer_dio_pkg;
    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [4:0] OFS_TIMER_IRQ_CLEAR = 5'h0C;
    localparam logic [4:0] OFS_PORT_A_DATA = 5'h10;
    localparam logic [4:0] OFS_PORT_B_DATA = 5'h11;
    localparam logic [4:0] OFS_PORT_C_DATA = 5'h12;
    localparam logic [4:0] OFS_DIGITAL_PORT_CONTROL = 5'h13;
    localparam logic [4:0] OFS_TIMER_A_CH0_DATA = 5'h14;
    localparam logic [4:0] OFS_TIMER_A_CH1_DATA = 5'h15;
    localparam logic [4:0] OFS_TIMER_A_CH2_DATA = 5'h16;
    localparam logic [4:0] OFS_TIMER_A_MODE = 5'h17;
    localparam logic [4:0] OFS_TIMER_B_CH0_DATA = 5'h18;
    localparam logic [4:0] OFS_TIMER_B_CH1_DATA = 5'h19;
    localparam logic [4:0] OFS_TIMER_B_CH2_DATA = 5'h1A;
    localparam logic [4:0] OFS_TIMER_B_MODE = 5'h1B;
    localparam logic [4:0] OFS_INTERVAL_COUNT_HOLD = 5'h1E;
    localparam logic [4:0] OFS_INTERVAL_COUNT_LOAD = 5'h1F;

    // ---------------------------------------------------------------
    // widths, indices, reset values
    // ---------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int COUNTER_SLOTS = 6;
    localparam logic [2:0] NO_COUNTER = 3'h7;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] CONTROL_RESET = 8'h9B;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // ---------------------------------------------------------------
    // timer mode byte fields
    // ---------------------------------------------------------------
    localparam int MODE_SEL_HI = 7;
    localparam int MODE_SEL_LO = 6;
    localparam int MODE_RL_HI = 5;
    localparam int MODE_RL_LO = 4;
    localparam int MODE_OP_HI = 3;
    localparam int MODE_OP_LO = 1;
    localparam int MODE_DECIMAL = 0;

    // ---------------------------------------------------------------
    // port control word fields
    // ---------------------------------------------------------------
    localparam int CW_MODE_SET = 7;
    localparam int CW_GROUP_A_HI = 6;
    localparam int CW_GROUP_A_LO = 5;
    localparam int CW_PORT_A_IN = 4;
    localparam int CW_PORT_C_HI_IN = 3;
    localparam int CW_GROUP_B_MODE = 2;
    localparam int CW_PORT_B_IN = 1;
    localparam int CW_PORT_C_LO_IN = 0;
    localparam int CW_BIT_SEL_HI = 3;
    localparam int CW_BIT_SEL_LO = 1;
    localparam int CW_BIT_VALUE = 0;
    localparam logic [7:0] PORT_C_HI_MASK = 8'hF0;
    localparam logic [7:0] PORT_C_LO_MASK = 8'h0F;
    localparam logic [7:0] HANDSHAKE_A_MASK = 8'hF8;
    localparam logic [7:0] HANDSHAKE_B_MASK = 8'h07;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] data;
    } bus_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic [DATA_W-1:0] enable;
    } port_drive_t;

    typedef struct packed {
        logic [1:0] counterSelect;
        logic [1:0] readLoadSel;
        logic [2:0] opMode;
        logic decimalCount;
    } timer_mode_t;

    typedef enum logic [1:0] {
        INTERVAL_IDLE = 2'b00,
        INTERVAL_ARMED = 2'b01
    } interval_state_t;
endpackage : timer_dio_pkg

// >>> core/timer_count_mem.sv
// small byte store for the six counter data bytes
`timescale 1ns/1ps
module timer_count_mem (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [2:0] wrIndex,
    input wire logic [7:0] wrData,
    input wire logic [2:0] rdIndex,
    output logic [7:0] rdData
);
    logic [7:0] store [0:timer_dio_pkg::COUNTER_SLOTS-1];

    // ---------------------------------------------------------------
    // write and registered read
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (wrEn && (wrIndex < 3'(timer_dio_pkg::COUNTER_SLOTS))) begin
            store[wrIndex] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (rdIndex < 3'(timer_dio_pkg::COUNTER_SLOTS)) begin
            rdData <= store[rdIndex];
        end else begin
            rdData <= timer_dio_pkg::BYTE_ZERO;
        end
    end
endmodule : timer_count_mem

// >>> core/timer_dio_interval_regs.sv
// register bank for counter/timers, digital i/o ports and interval counter
// Summary of operation
// R1: offsets 0x14-0x16 read/write counter bytes of timer group A.
// R2: offset 0x17 write-only mode byte for timer group A.
// R3: mode byte: select 7..6, read/load 5..4, op mode 3..1, decimal 0.
// R4: any write to 0x0C clears the pending timer interrupt unless a low pulse is seen in the same cycle.
// R5: offsets 0x18-0x1A read/write counter bytes of timer group B.
// R6: offset 0x1B write-only mode byte for group B, same layout.
// R7: 24 digital lines as three 8-bit ports, grouped or independent.
// R8: 0x10 reads port A levels; writes drive port A when output.
// R9: 0x11 reads port B levels; writes drive port B when output.
// R10: port C plain except bits taken as handshake by strobed A (7..3) or strobed B (2..0).
// R11: 0x13 write-only control word sets directions and transfer modes.
// R12: interval counter runs only when scan off and interval scan on.
// R13: 0x1E write-only holding register for interval count.
// R14: write to 0x1F copies holding value into counter and arms it.
// R15: armed interval counter decrements once per conversion pulse.
// R16: a step at a count of one or less reloads the interval counter from the holding register.
// R17: software writes 0x01 to the interval strobe port.
// R18: timer interrupt stays set after its low pulse until cleared.
// R19: reads of write-only offsets change no state.
`timescale 1ns/1ps
module timer_dio_interval_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input timer_dio_pkg::bus_req_t busReq,
    output logic [7:0] rdData,
    output logic rdValid,
    input wire logic [7:0] port_a_lines,
    input wire logic [7:0] port_b_lines,
    input wire logic [7:0] portCLines,
    output timer_dio_pkg::port_drive_t portADrive,
    output timer_dio_pkg::port_drive_t portBDrive,
    output timer_dio_pkg::port_drive_t portCDrive,
    output logic [7:0] port_control_word,
    input wire logic timerA2Out,
    input wire logic external_update_n,
    output logic timerIrq,
    output timer_dio_pkg::timer_mode_t timerAMode,
    output timer_dio_pkg::timer_mode_t timerBMode,
    output logic counterLoad,
    output logic [2:0] counterLoadIndex,
    output logic [7:0] counterLoadData,
    input wire logic scan_enable,
    input wire logic interval_scan_select,
    input wire logic convPulse,
    output logic [7:0] intervalCount,
    output logic intervalArmed,
    output logic intervalWrap
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [2:0] counterIndex(input logic [4:0] addr);
        case (addr)
            timer_dio_pkg::OFS_TIMER_A_CH0_DATA: counterIndex = 3'd0;
            timer_dio_pkg::OFS_TIMER_A_CH1_DATA: counterIndex = 3'd1;
            timer_dio_pkg::OFS_TIMER_A_CH2_DATA: counterIndex = 3'd2;
            timer_dio_pkg::OFS_TIMER_B_CH0_DATA: counterIndex = 3'd3;
            timer_dio_pkg::OFS_TIMER_B_CH1_DATA: counterIndex = 3'd4;
            timer_dio_pkg::OFS_TIMER_B_CH2_DATA: counterIndex = 3'd5;
            default: counterIndex = timer_dio_pkg::NO_COUNTER;
        endcase
    endfunction : counterIndex

    function automatic logic writeTo(input timer_dio_pkg::bus_req_t req, input logic [4:0] ofs);
        writeTo = req.wr && (req.addr == ofs);
    endfunction : writeTo

    function automatic timer_dio_pkg::timer_mode_t modeFields(input logic [7:0] b);
        modeFields.counterSelect = b[timer_dio_pkg::MODE_SEL_HI:timer_dio_pkg::MODE_SEL_LO];
        modeFields.readLoadSel = b[timer_dio_pkg::MODE_RL_HI:timer_dio_pkg::MODE_RL_LO];
        modeFields.opMode = b[timer_dio_pkg::MODE_OP_HI:timer_dio_pkg::MODE_OP_LO];
        modeFields.decimalCount = b[timer_dio_pkg::MODE_DECIMAL];
    endfunction : modeFields

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [7:0] portASync1_reg, portASync2_reg;
    logic [7:0] portBSync1_reg, portBSync2_reg;
    logic [7:0] portCSync1_reg, portCSync2_reg;
    logic [2:0] evtSync1_reg, evtSync2_reg;
    logic [1:0] evtPrev_reg;

    always_ff @(posedge clk) begin
        portASync1_reg <= port_a_lines;
        portASync2_reg <= portASync1_reg;
        portBSync1_reg <= port_b_lines;
        portBSync2_reg <= portBSync1_reg;
        portCSync1_reg <= portCLines;
        portCSync2_reg <= portCSync1_reg;
        evtSync1_reg <= {convPulse, external_update_n, timerA2Out};
        evtSync2_reg <= evtSync1_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evtPrev_reg <= 2'b11;
        end else begin
            evtPrev_reg <= evtSync2_reg[1:0];
        end
    end

    // ---------------------------------------------------------------
    // timer interrupt
    // ---------------------------------------------------------------
    logic lowPulseSeen;
    assign lowPulseSeen = |(evtPrev_reg & ~evtSync2_reg[1:0]);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timerIrq <= 1'b0;
        end else if (lowPulseSeen) begin
            timerIrq <= 1'b1; // [R18]
        end else if (writeTo(busReq, timer_dio_pkg::OFS_TIMER_IRQ_CLEAR)) begin
            timerIrq <= 1'b0; // [R4]
        end
    end

    // ---------------------------------------------------------------
    // counter data and mode bytes
    // ---------------------------------------------------------------
    logic [2:0] wrCounter;
    logic [7:0] counterByte;
    assign wrCounter = counterIndex(busReq.addr);

    timer_count_mem countStore (
        .clk(clk),
        .wrEn(busReq.wr && (wrCounter != timer_dio_pkg::NO_COUNTER)), // [R1] [R5]
        .wrIndex(wrCounter),
        .wrData(busReq.data),
        .rdIndex(wrCounter),
        .rdData(counterByte)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            counterLoad <= 1'b0;
            counterLoadIndex <= 3'd0;
            counterLoadData <= timer_dio_pkg::BYTE_ZERO;
        end else begin
            counterLoad <= busReq.wr && (wrCounter != timer_dio_pkg::NO_COUNTER); // [R1] [R5]
            if (busReq.wr && (wrCounter != timer_dio_pkg::NO_COUNTER)) begin
                counterLoadIndex <= wrCounter;
                counterLoadData <= busReq.data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timerAMode <= modeFields(timer_dio_pkg::MODE_RESET);
            timerBMode <= modeFields(timer_dio_pkg::MODE_RESET);
        end else begin
            if (writeTo(busReq, timer_dio_pkg::OFS_TIMER_A_MODE)) begin
                timerAMode <= modeFields(busReq.data); // [R2] [R3]
            end
            if (writeTo(busReq, timer_dio_pkg::OFS_TIMER_B_MODE)) begin
                timerBMode <= modeFields(busReq.data); // [R6] [R3]
            end
        end
    end

    // ---------------------------------------------------------------
    // digital i/o ports
    // ---------------------------------------------------------------
    logic [7:0] portAOut_reg, portBOut_reg, portCOut_reg;
    logic portAIsOut, portBIsOut, strobedA, strobedB;
    logic [7:0] portCOutMask, portCPlainMask;
    logic [2:0] bitSel;

    assign portAIsOut = ~port_control_word[timer_dio_pkg::CW_PORT_A_IN];
    assign portBIsOut = ~port_control_word[timer_dio_pkg::CW_PORT_B_IN];
    assign strobedA = |port_control_word[timer_dio_pkg::CW_GROUP_A_HI:timer_dio_pkg::CW_GROUP_A_LO];
    assign strobedB = port_control_word[timer_dio_pkg::CW_GROUP_B_MODE];
    assign bitSel = busReq.data[timer_dio_pkg::CW_BIT_SEL_HI:timer_dio_pkg::CW_BIT_SEL_LO];
    assign portCPlainMask = ~((strobedA ? timer_dio_pkg::HANDSHAKE_A_MASK
                                        : timer_dio_pkg::BYTE_ZERO)
                            | (strobedB ? timer_dio_pkg::HANDSHAKE_B_MASK
                                        : timer_dio_pkg::BYTE_ZERO)); // [R10]
    assign portCOutMask = portCPlainMask
        & ((port_control_word[timer_dio_pkg::CW_PORT_C_HI_IN] ? timer_dio_pkg::BYTE_ZERO
                                                           : timer_dio_pkg::PORT_C_HI_MASK)
        | (port_control_word[timer_dio_pkg::CW_PORT_C_LO_IN] ? timer_dio_pkg::BYTE_ZERO
                                                          : timer_dio_pkg::PORT_C_LO_MASK));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_control_word <= timer_dio_pkg::CONTROL_RESET;
        end else if (writeTo(busReq, timer_dio_pkg::OFS_DIGITAL_PORT_CONTROL)
                     && busReq.data[timer_dio_pkg::CW_MODE_SET]) begin
            port_control_word <= busReq.data; // [R11] [R7]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            portAOut_reg <= timer_dio_pkg::BYTE_ZERO;
            portBOut_reg <= timer_dio_pkg::BYTE_ZERO;
        end else begin
            if (writeTo(busReq, timer_dio_pkg::OFS_DIGITAL_PORT_CONTROL)
                && busReq.data[timer_dio_pkg::CW_MODE_SET]) begin
                portAOut_reg <= timer_dio_pkg::BYTE_ZERO;
                portBOut_reg <= timer_dio_pkg::BYTE_ZERO;
            end else begin
                if (writeTo(busReq, timer_dio_pkg::OFS_PORT_A_DATA)) begin
                    portAOut_reg <= busReq.data; // [R8]
                end
                if (writeTo(busReq, timer_dio_pkg::OFS_PORT_B_DATA)) begin
                    portBOut_reg <= busReq.data; // [R9]
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            portCOut_reg <= timer_dio_pkg::BYTE_ZERO;
        end else if (writeTo(busReq, timer_dio_pkg::OFS_DIGITAL_PORT_CONTROL)) begin
            if (busReq.data[timer_dio_pkg::CW_MODE_SET]) begin
                portCOut_reg <= timer_dio_pkg::BYTE_ZERO;
            end else begin
                portCOut_reg[bitSel] <= busReq.data[timer_dio_pkg::CW_BIT_VALUE];
            end
        end else if (writeTo(busReq, timer_dio_pkg::OFS_PORT_C_DATA)) begin
            portCOut_reg <= (portCOut_reg & ~portCPlainMask)
                          | (busReq.data & portCPlainMask); // [R10]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            portADrive <= '0;
            portBDrive <= '0;
            portCDrive <= '0;
        end else begin
            portADrive.value <= portAOut_reg;
            portADrive.enable <= portAIsOut ? timer_dio_pkg::BYTE_ONES
                                            : timer_dio_pkg::BYTE_ZERO; // [R8]
            portBDrive.value <= portBOut_reg;
            portBDrive.enable <= portBIsOut ? timer_dio_pkg::BYTE_ONES
                                            : timer_dio_pkg::BYTE_ZERO; // [R9]
            portCDrive.value <= portCOut_reg;
            portCDrive.enable <= portCOutMask; // [R10]
        end
    end

    // ---------------------------------------------------------------
    // interval counter
    // ---------------------------------------------------------------
    timer_dio_pkg::interval_state_t intervalState_reg, intervalState_next;
    logic [7:0] intervalHold_reg;
    logic convSeen, intervalMode, countStep;
    logic evtPrev2_reg;

    assign convSeen = evtSync2_reg[2] & ~evtPrev2_reg;
    assign intervalMode = ~scan_enable & interval_scan_select; // [R12]
    assign countStep = (intervalState_reg == timer_dio_pkg::INTERVAL_ARMED)
                       && intervalMode && convSeen;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evtPrev2_reg <= 1'b0;
        end else begin
            evtPrev2_reg <= evtSync2_reg[2];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            intervalHold_reg <= timer_dio_pkg::BYTE_ZERO;
        end else if (writeTo(busReq, timer_dio_pkg::OFS_INTERVAL_COUNT_HOLD)) begin
            intervalHold_reg <= busReq.data; // [R13]
        end
    end

    always_comb begin
        intervalState_next = intervalState_reg;
        case (intervalState_reg)
            timer_dio_pkg::INTERVAL_IDLE: begin
                if (writeTo(busReq, timer_dio_pkg::OFS_INTERVAL_COUNT_LOAD)) begin
                    intervalState_next = timer_dio_pkg::INTERVAL_ARMED; // [R14]
                end
            end
            timer_dio_pkg::INTERVAL_ARMED: begin
                intervalState_next = timer_dio_pkg::INTERVAL_ARMED;
            end
            default: begin
                intervalState_next = timer_dio_pkg::INTERVAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            intervalState_reg <= timer_dio_pkg::INTERVAL_IDLE;
        end else begin
            intervalState_reg <= intervalState_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            intervalCount <= timer_dio_pkg::BYTE_ZERO;
            intervalWrap <= 1'b0;
            intervalArmed <= 1'b0;
        end else begin
            intervalArmed <= (intervalState_next == timer_dio_pkg::INTERVAL_ARMED);
            intervalWrap <= 1'b0;
            if (writeTo(busReq, timer_dio_pkg::OFS_INTERVAL_COUNT_LOAD)) begin
                intervalCount <= intervalHold_reg; // [R14] [R17]
            end else if (countStep) begin
                if (intervalCount <= timer_dio_pkg::COUNT_ONE) begin
                    intervalCount <= intervalHold_reg; // [R16]
                    intervalWrap <= 1'b1;
                end else begin
                    intervalCount <= intervalCount - timer_dio_pkg::COUNT_ONE; // [R15]
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // read path, two cycles from request to data
    // ---------------------------------------------------------------
    logic rdPend_reg, rdFromCounter_reg;
    logic [7:0] rdStage_reg;
    logic [7:0] rdMux;

    always_comb begin
        case (busReq.addr)
            timer_dio_pkg::OFS_PORT_A_DATA: rdMux = portASync2_reg; // [R8]
            timer_dio_pkg::OFS_PORT_B_DATA: rdMux = portBSync2_reg; // [R9]
            timer_dio_pkg::OFS_PORT_C_DATA: rdMux = portCSync2_reg; // [R10]
            default: rdMux = timer_dio_pkg::BYTE_ZERO; // [R19]
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdPend_reg <= 1'b0;
            rdFromCounter_reg <= 1'b0;
            rdStage_reg <= timer_dio_pkg::BYTE_ZERO;
        end else begin
            rdPend_reg <= busReq.rd;
            rdFromCounter_reg <= (wrCounter != timer_dio_pkg::NO_COUNTER); // [R1] [R5]
            rdStage_reg <= rdMux;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData <= timer_dio_pkg::BYTE_ZERO;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdPend_reg;
            if (rdPend_reg) begin
                rdData <= rdFromCounter_reg ? counterByte : rdStage_reg;
            end
        end
    end
endmodule : timer_dio_interval_regs

// >>> testbench/timer_dio_interval_regs_assertions.sv
// checks on bank ports
`timescale 1ns/1ps
module timer_dio_interval_regs_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input timer_dio_pkg::bus_req_t busReq,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire logic timerIrq,
    input timer_dio_pkg::timer_mode_t timerAMode,
    input timer_dio_pkg::timer_mode_t timerBMode,
    input wire logic counterLoad,
    input wire logic [2:0] counterLoadIndex,
    input wire logic [7:0] counterLoadData,
    input wire logic [7:0] intervalCount,
    input wire logic intervalArmed,
    input wire logic intervalWrap
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence readReq; busReq.rd; endsequence
    sequence wrAt(logic [4:0] a); busReq.wr && busReq.addr == a; endsequence
    wire logic clrWr = busReq.wr && busReq.addr == 5'h0C;
    wire logic strobeWr = busReq.wr && busReq.addr == 5'h1F;
    a_read_answer_lag: assert property (readReq |-> ##2 rdValid)
        else $error("read answer late");
    a_answer_has_cause: assert property (rdValid |-> $past(busReq.rd, 2))
        else $error("read answer without request");
    a_wo_read_zero: assert property (busReq.rd && busReq.addr inside
        {5'h0C, 5'h13, 5'h17, 5'h1B, 5'h1E, 5'h1F} |-> ##2 rdData == 8'h00)
        else $error("write-only read not zero");
    a_irq_holds_set: assert property (timerIrq && !clrWr |=> timerIrq)
        else $error("irq dropped without clear");
    a_irq_clear_cause: assert property ($fell(timerIrq) |-> $past(clrWr))
        else $error("irq fell without clear write");
    a_mode_a_load: assert property (wrAt(5'h17) |=> timerAMode == $past(busReq.data))
        else $error("mode a not loaded");
    a_mode_b_load: assert property (wrAt(5'h1B) |=> timerBMode == $past(busReq.data))
        else $error("mode b not loaded");
    a_counter_a0_load: assert property (wrAt(5'h14) |=> counterLoad
        && counterLoadIndex == 3'h0 && counterLoadData == $past(busReq.data))
        else $error("counter a0 load wrong");
    a_counter_b2_load: assert property (wrAt(5'h1A) |=> counterLoad
        && counterLoadIndex == 3'h5 && counterLoadData == $past(busReq.data))
        else $error("counter b2 load wrong");
    a_strobe_arms: assert property (strobeWr |=> intervalArmed)
        else $error("strobe did not arm");
    a_count_step: assert property ($changed(intervalCount) && !$past(strobeWr)
        |-> intervalWrap || intervalCount == $past(intervalCount) - 8'h01)
        else $error("interval count jumped");
endmodule : timer_dio_interval_regs_assertions

bind timer_dio_interval_regs timer_dio_interval_regs_assertions chk (
    .clk, .sys_rst, .busReq, .rdData, .rdValid, .timerIrq, .timerAMode, .timerBMode,
    .counterLoad, .counterLoadIndex, .counterLoadData, .intervalCount,
    .intervalArmed, .intervalWrap
);

// >>> testbench/pin_side_model.sv
// far-side pin model
`timescale 1ns/1ps
module pin_side_model (
    input timer_dio_pkg::port_drive_t portADrive,
    input timer_dio_pkg::port_drive_t portBDrive,
    input timer_dio_pkg::port_drive_t portCDrive,
    input wire logic [7:0] extIn,
    output logic [7:0] portALevel,
    output logic [7:0] portBLevel,
    output logic [7:0] portCLevel
);
    logic [7:0] extB;
    logic [7:0] extC;
    assign extB = extIn ^ 8'h3C;
    assign extC = {extIn[3:0], extIn[7:4]};
    assign portALevel = (portADrive.value & portADrive.enable) | (extIn & ~portADrive.enable);
    assign portBLevel = (portBDrive.value & portBDrive.enable) | (extB & ~portBDrive.enable);
    assign portCLevel = (portCDrive.value & portCDrive.enable) | (extC & ~portCDrive.enable);
endmodule : pin_side_model

// >>> testbench/timer_dio_interval_regs_bench.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
module timer_dio_interval_regs_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    timer_dio_pkg::bus_req_t busReq = '0;
    logic timerA2Out = 1'b1;
    logic external_update_n = 1'b1;
    logic scan_enable = 1'b0;
    logic interval_scan_select = 1'b1;
    logic convPulse = 1'b0;
    logic [7:0] extIn = 8'hA5;
    logic [7:0] rdData, port_a_lines, port_b_lines, portCLines, port_control_word, intervalCount;
    logic rdValid, timerIrq, intervalArmed;
    timer_dio_pkg::port_drive_t portADrive, portBDrive, portCDrive;
    timer_dio_pkg::timer_mode_t timerAMode, timerBMode;
    logic [4:0] woList [6] = '{5'h0C, 5'h13, 5'h17, 5'h1B, 5'h1E, 5'h1F};
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    timer_dio_interval_regs uut (.clk, .sys_rst, .busReq, .rdData, .rdValid,
        .port_a_lines, .port_b_lines, .portCLines, .portADrive, .portBDrive, .portCDrive,
        .port_control_word, .timerA2Out, .external_update_n, .timerIrq, .timerAMode,
        .timerBMode, .counterLoad(), .counterLoadIndex(), .counterLoadData(), .scan_enable,
        .interval_scan_select, .convPulse, .intervalCount, .intervalArmed, .intervalWrap());
    pin_side_model pins (.portADrive, .portBDrive, .portCDrive, .extIn,
        .portALevel(port_a_lines), .portBLevel(port_b_lines), .portCLevel(portCLines));
    task automatic print_verdict();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk) busReq <= '{a, 1'b0, 1'b1, d};
        @(posedge clk) busReq.wr <= 1'b0;
    endtask : wr
    task automatic rdChk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk) busReq <= '{a, 1'b1, 1'b0, 8'h00};
        @(posedge clk) busReq.rd <= 1'b0;
        idle(1);
        check(rdValid, 1'b1);
        check(rdData, exp);
    endtask : rdChk
    task automatic conv();
        @(posedge clk) convPulse <= 1'b1;
        repeat (3) @(posedge clk);
        convPulse <= 1'b0;
        idle(6);
    endtask : conv
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        idle(1);
        check(port_control_word, 8'h9B);
        for (int i = 0; i < 6; i++) wr(i < 3 ? 5'h14 + i : 5'h15 + i, 8'h11 * (i + 1));
        for (int i = 0; i < 6; i++) rdChk(i < 3 ? 5'h14 + i : 5'h15 + i, 8'h11 * (i + 1));
        wr(5'h17, 8'hB5);
        idle(1);
        check(timerAMode, 8'hB5);
        wr(5'h1B, 8'h6A);
        idle(1);
        check(timerBMode, 8'h6A);
        foreach (woList[k]) rdChk(woList[k], 8'h00);
        check(timerAMode, 8'hB5);
        wr(5'h13, 8'h80);
        idle(1);
        check(port_control_word, 8'h80);
        wr(5'h10, 8'h55);
        wr(5'h11, 8'hAA);
        wr(5'h12, 8'h3C);
        idle(6);
        check(portADrive.enable, 8'hFF);
        rdChk(5'h10, 8'h55);
        rdChk(5'h11, 8'hAA);
        rdChk(5'h12, 8'h3C);
        wr(5'h13, 8'h9B);
        idle(6);
        check(portBDrive.enable, 8'h00);
        rdChk(5'h10, 8'hA5);
        rdChk(5'h11, 8'h99);
        rdChk(5'h12, 8'h5A);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk) {timerA2Out, external_update_n} <= j == 0 ? 2'b01 : 2'b10;
            repeat (2) @(posedge clk);
            {timerA2Out, external_update_n} <= 2'b11;
            idle(6);
            check(timerIrq, 1'b1);
            idle(20);
            check(timerIrq, 1'b1);
            wr(5'h0C, 8'h5A);
            idle(1);
            check(timerIrq, 1'b0);
        end
        wr(5'h1E, 8'h03);
        wr(5'h1F, 8'h01);
        idle(1);
        check(intervalCount, 8'h03);
        check(intervalArmed, 1'b1);
        conv();
        check(intervalCount, 8'h02);
        conv();
        check(intervalCount, 8'h01);
        conv();
        check(intervalCount, 8'h03);
        @(posedge clk) interval_scan_select <= 1'b0;
        conv();
        check(intervalCount, 8'h03);
        @(posedge clk) {scan_enable, interval_scan_select} <= 2'b11;
        conv();
        check(intervalCount, 8'h03);
        @(posedge clk) scan_enable <= 1'b0;
        conv();
        check(intervalCount, 8'h02);
        print_verdict();
    end
endmodule : timer_dio_interval_regs_bench
